// [common/pmc_pkg.sv]
// Package for the power mode controller: register map, field positions,
// reset values, mode encodings and bus carrier types.
// Assumes a single AHB-Lite master and a 25 MHz core clock.
package pmc_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFF_PCTL_FIRST  = 8'h00; // power_control_first
  localparam logic [7:0] OFF_PCTL_SECOND = 8'h04; // power_control_second
  localparam logic [7:0] OFF_REG_CTRL    = 8'h08; // regulator_control
  localparam logic [7:0] OFF_CLK_SEL     = 8'h0c; // clock select and divider
  localparam logic [7:0] OFF_PERIPH_EN   = 8'h10; // peripheral clock enables
  localparam logic [7:0] OFF_STATUS      = 8'h14; // mode status, read only

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int BIT_IDLE     = 0;  // power_control_first
  localparam int BIT_STOP     = 1;  // power_control_first
  localparam int BIT_SUSPEND  = 0;  // power_control_second
  localparam int BIT_SNOOZE   = 1;  // power_control_second
  localparam int BIT_STOPCFG  = 0;  // regulator_control: stop_config_select
  localparam int BIT_T34_SLOW = 1;  // regulator_control: timers 3/4 on slow clock
  localparam int POS_SRC      = 0;  // clock select [1:0]
  localparam int POS_DIV      = 4;  // clock select [6:4]
  localparam int BIT_PRE15    = 8;  // clock select: 1.5x prescaler

  // ---------------------------------------------------------------------
  // Reset values and widths
  // ---------------------------------------------------------------------
  localparam int          PERIPH_W      = 8;
  localparam logic [1:0]  RST_SRC       = 2'h0;  // fast_osc_24m
  localparam logic [2:0]  RST_DIV       = 3'h3;  // divide by 8
  localparam logic [7:0]  RST_PERIPH_EN = 8'h00;
  localparam logic [2:0]  SLOW_DIV_LAST = 3'h7;  // slow clock divided by 8

  // System clock sources
  localparam logic [1:0] SRC_FAST24 = 2'h0;
  localparam logic [1:0] SRC_FAST72 = 2'h1;
  localparam logic [1:0] SRC_SLOW   = 2'h2;
  localparam logic [1:0] SRC_EXT    = 2'h3;

  // Power modes, one-hot
  typedef enum logic [5:0] {
    PM_NORMAL   = 6'h01,
    PM_IDLE     = 6'h02,
    PM_SUSPEND  = 6'h04,
    PM_SNOOZE   = 6'h08,
    PM_STOP     = 6'h10,
    PM_SHUTDOWN = 6'h20
  } pmc_mode_t;

  // Wake sources for suspend and snooze
  typedef struct packed {
    logic timer4;
    logic spi;
    logic i2c;
    logic port_match;
    logic cmp0;
    logic clu;
  } pmc_wake_t;

  // AHB-Lite request
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } pmc_ahb_req_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// [rtl/pmc_top.sv]
// Power mode controller: AHB-Lite register slave, power mode sequencer,
// clock source and divider selection, clock gating and oscillator control.
// Assumes all inputs are synchronous to core_clk; wake inputs are levels.
//
// Behaviour
// RULE_01: In normal mode the core clock and all enabled peripheral clocks run.
// RULE_02: The idle bit halts the core, keeps peripherals clocked, any interrupt wakes.
// RULE_03: Suspend bit, set with the 24.5 MHz source chosen, halts clocks and fast oscillators, normal bias.
// RULE_04: Snooze bit does the same as suspend but puts the regulator in low bias.
// RULE_05: Waking from idle, suspend or snooze resumes execution with no reset.
// RULE_06: Suspend and snooze wake on timer 4, SPI, I2C target, port match, comparator 0 rise or logic unit event.
// RULE_07: In suspend and snooze timers 3 and 4 may count from the slow oscillator divided by 8.
// RULE_08: Stop bit with stop config clear powers down, holds pins, leaves on any reset.
// RULE_09: Stop bit with stop config set powers down, holds pins, leaves only on pin or power-on reset.
// RULE_10: Each digital peripheral clock is gated off while that peripheral is unused.
// RULE_11: Out of reset the system clock is the 24.5 MHz oscillator divided by 8.
// RULE_12: The divider offers divide by 1, 2, 4, 8, 16, 32, 64 and 128.
// RULE_13: Both fast oscillators offer an extra 1.5x prescaler before the divider.
// RULE_14: Idle, suspend and snooze request bits clear themselves on wake.
`timescale 1ns/1ps
module pmc_top #(
  parameter int PERIPH_W = pmc_pkg::PERIPH_W
) (
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 clk_en,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Events
  input  wire logic                 irq_any,
  input  wire logic                 wake_timer4,
  input  wire logic                 wake_spi,
  input  wire logic                 wake_i2c,
  input  wire logic                 wake_port_match,
  input  wire logic                 cmp0_level,
  input  wire logic                 wake_clu,
  input  wire logic                 any_reset,
  input  wire logic                 pin_or_por_reset,
  input  wire logic                 slow_osc_tick,
  // Power and clock controls
  output logic                      core_clk_en,
  output logic [PERIPH_W-1:0]       periph_clk_en,
  output logic                      fast_osc_24m_en,
  output logic                      fast_osc_72m_en,
  output logic                      reg_low_bias,
  output logic                      power_nets_off,
  output logic                      pin_hold,
  output logic [1:0]                clk_src,
  output logic [7:0]                clk_div_ratio,
  output logic                      clk_pre15,
  output logic                      timer34_tick,
  output logic [5:0]                power_mode
);

  // ---------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------
  // Divider code to ratio, 1 to 128
  function automatic logic [7:0] div_ratio(input logic [2:0] code);
    div_ratio = 8'h01 << code; // [RULE_12]
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ---------------------------------------------------------------------
  // Bus address phase capture
  // ---------------------------------------------------------------------
  logic       dp_wr;
  logic [7:0] dp_addr;
  logic       next_dp_wr;
  logic [7:0] next_dp_addr;
  logic       take;

  // Latch a valid single transfer for its data phase
  always_comb begin
    take         = hsel && hready && (htrans == pmc_pkg::HTRANS_NONSEQ);
    next_dp_wr   = take && hwrite;
    next_dp_addr = take ? haddr[7:0] : dp_addr;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else if (clk_en) begin
      dp_wr   <= next_dp_wr;
      dp_addr <= next_dp_addr;
    end
  end

  // ---------------------------------------------------------------------
  // Registers and mode sequencer
  // ---------------------------------------------------------------------
  logic                idle_req, stop_req, susp_req, snz_req;
  logic                stop_cfg, t34_slow, pre15;
  logic [1:0]          src;
  logic [2:0]          div;
  logic [PERIPH_W-1:0] pen;
  pmc_pkg::pmc_mode_t  mode;
  logic                cmp0_prev;
  logic [2:0]          slow_cnt;
  logic                next_idle_req, next_stop_req, next_susp_req, next_snz_req;
  logic                next_stop_cfg, next_t34_slow, next_pre15;
  logic [1:0]          next_src;
  logic [2:0]          next_div;
  logic [PERIPH_W-1:0] next_pen;
  pmc_pkg::pmc_mode_t  next_mode;
  logic [2:0]          next_slow_cnt;
  logic                next_t34_tick;
  pmc_pkg::pmc_wake_t  wk;
  logic                deep_wake;

  // Register writes, mode transitions and wake handling
  always_comb begin
    next_idle_req = idle_req;
    next_stop_req = stop_req;
    next_susp_req = susp_req;
    next_snz_req  = snz_req;
    next_stop_cfg = stop_cfg;
    next_t34_slow = t34_slow;
    next_pre15    = pre15;
    next_src      = src;
    next_div      = div;
    next_pen      = pen;
    next_mode     = mode;
    next_slow_cnt = slow_cnt;
    next_t34_tick = 1'b0;
    wk.timer4     = wake_timer4;
    wk.spi        = wake_spi;
    wk.i2c        = wake_i2c;
    wk.port_match = wake_port_match;
    wk.cmp0       = cmp0_level && !cmp0_prev;
    wk.clu        = wake_clu;
    deep_wake     = |wk; // [RULE_06]
    if (dp_wr) begin
      if (hit(dp_addr, pmc_pkg::OFF_PCTL_FIRST)) begin
        next_idle_req = hwdata[pmc_pkg::BIT_IDLE];
        next_stop_req = hwdata[pmc_pkg::BIT_STOP];
      end else if (hit(dp_addr, pmc_pkg::OFF_PCTL_SECOND)) begin
        // Suspend and snooze only honoured on the 24.5 MHz source
        next_susp_req = hwdata[pmc_pkg::BIT_SUSPEND] && (src == pmc_pkg::SRC_FAST24); // [RULE_03]
        next_snz_req  = hwdata[pmc_pkg::BIT_SNOOZE] && (src == pmc_pkg::SRC_FAST24);  // [RULE_04]
      end else if (hit(dp_addr, pmc_pkg::OFF_REG_CTRL)) begin
        next_stop_cfg = hwdata[pmc_pkg::BIT_STOPCFG];
        next_t34_slow = hwdata[pmc_pkg::BIT_T34_SLOW];
      end else if (hit(dp_addr, pmc_pkg::OFF_CLK_SEL)) begin
        next_src   = hwdata[pmc_pkg::POS_SRC +: 2];
        next_div   = hwdata[pmc_pkg::POS_DIV +: 3];   // [RULE_12]
        next_pre15 = hwdata[pmc_pkg::BIT_PRE15];      // [RULE_13]
      end else if (hit(dp_addr, pmc_pkg::OFF_PERIPH_EN)) begin
        next_pen = hwdata[PERIPH_W-1:0];              // [RULE_10]
      end
    end
    case (mode)
      pmc_pkg::PM_NORMAL: begin
        if (stop_req) begin
          next_mode = stop_cfg ? pmc_pkg::PM_SHUTDOWN : pmc_pkg::PM_STOP; // [RULE_08] [RULE_09]
        end else if (susp_req) begin
          next_mode = pmc_pkg::PM_SUSPEND;
        end else if (snz_req) begin
          next_mode = pmc_pkg::PM_SNOOZE;
        end else if (idle_req) begin
          next_mode = pmc_pkg::PM_IDLE;
        end
      end
      pmc_pkg::PM_IDLE: begin
        if (irq_any) begin
          next_mode     = pmc_pkg::PM_NORMAL; // [RULE_02] [RULE_05]
          next_idle_req = 1'b0;               // [RULE_14]
        end
      end
      pmc_pkg::PM_SUSPEND, pmc_pkg::PM_SNOOZE: begin
        if (deep_wake) begin
          next_mode     = pmc_pkg::PM_NORMAL; // [RULE_05]
          next_susp_req = 1'b0;               // [RULE_14]
          next_snz_req  = 1'b0;
        end
      end
      pmc_pkg::PM_STOP: begin
        if (any_reset || pin_or_por_reset) begin
          next_mode     = pmc_pkg::PM_NORMAL; // [RULE_08]
          next_stop_req = 1'b0;
        end
      end
      pmc_pkg::PM_SHUTDOWN: begin
        if (pin_or_por_reset) begin
          next_mode     = pmc_pkg::PM_NORMAL; // [RULE_09]
          next_stop_req = 1'b0;
        end
      end
      default: next_mode = pmc_pkg::PM_NORMAL;
    endcase
    // Slow oscillator divided by 8 for timers 3 and 4
    if (slow_osc_tick) begin
      next_slow_cnt = slow_cnt + 3'h1;
      next_t34_tick = t34_slow && (slow_cnt == pmc_pkg::SLOW_DIV_LAST); // [RULE_07]
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      idle_req  <= 1'b0;
      stop_req  <= 1'b0;
      susp_req  <= 1'b0;
      snz_req   <= 1'b0;
      stop_cfg  <= 1'b0;
      t34_slow  <= 1'b0;
      pre15     <= 1'b0;
      src       <= pmc_pkg::RST_SRC;   // [RULE_11]
      div       <= pmc_pkg::RST_DIV;   // [RULE_11]
      pen       <= PERIPH_W'(pmc_pkg::RST_PERIPH_EN);
      mode      <= pmc_pkg::PM_NORMAL;
      cmp0_prev <= 1'b0;
      slow_cnt  <= 3'h0;
      timer34_tick <= 1'b0;
    end else if (clk_en) begin
      idle_req  <= next_idle_req;
      stop_req  <= next_stop_req;
      susp_req  <= next_susp_req;
      snz_req   <= next_snz_req;
      stop_cfg  <= next_stop_cfg;
      t34_slow  <= next_t34_slow;
      pre15     <= next_pre15;
      src       <= next_src;
      div       <= next_div;
      pen       <= next_pen;
      mode      <= next_mode;
      cmp0_prev <= cmp0_level;
      slow_cnt  <= next_slow_cnt;
      timer34_tick <= next_t34_tick;
    end
  end

  // ---------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------
  logic [31:0] next_rdata;
  logic        run, deep, off;

  // Read mux decoded in the address phase, so hrdata stands through the data phase
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (take && !hwrite) begin
      if (hit(haddr[7:0], pmc_pkg::OFF_PCTL_FIRST)) begin
        next_rdata = {30'h0, next_stop_req, next_idle_req};
      end else if (hit(haddr[7:0], pmc_pkg::OFF_PCTL_SECOND)) begin
        next_rdata = {30'h0, next_snz_req, next_susp_req};
      end else if (hit(haddr[7:0], pmc_pkg::OFF_REG_CTRL)) begin
        next_rdata = {30'h0, next_t34_slow, next_stop_cfg};
      end else if (hit(haddr[7:0], pmc_pkg::OFF_CLK_SEL)) begin
        next_rdata = {23'h0, next_pre15, 1'b0, next_div, 2'h0, next_src};
      end else if (hit(haddr[7:0], pmc_pkg::OFF_PERIPH_EN)) begin
        next_rdata = 32'(next_pen);
      end else if (hit(haddr[7:0], pmc_pkg::OFF_STATUS)) begin
        next_rdata = {26'h0, next_mode};
      end
    end
    run  = (next_mode == pmc_pkg::PM_NORMAL);                            // [RULE_01]
    deep = (next_mode == pmc_pkg::PM_SUSPEND) || (next_mode == pmc_pkg::PM_SNOOZE);
    off  = (next_mode == pmc_pkg::PM_STOP) || (next_mode == pmc_pkg::PM_SHUTDOWN);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata          <= 32'h0000_0000;
      hreadyout       <= 1'b1;
      hresp           <= 1'b0;
      core_clk_en     <= 1'b1;
      periph_clk_en   <= '0;
      fast_osc_24m_en <= 1'b1;
      fast_osc_72m_en <= 1'b0;
      reg_low_bias    <= 1'b0;
      power_nets_off  <= 1'b0;
      pin_hold        <= 1'b0;
      clk_src         <= pmc_pkg::RST_SRC;
      clk_div_ratio   <= div_ratio(pmc_pkg::RST_DIV);
      clk_pre15       <= 1'b0;
      power_mode      <= pmc_pkg::PM_NORMAL;
    end else if (clk_en) begin
      hrdata          <= next_rdata;
      hreadyout       <= 1'b1;
      hresp           <= 1'b0;
      core_clk_en     <= run;                                   // [RULE_01] [RULE_02]
      periph_clk_en   <= (deep || off) ? '0 : next_pen;         // [RULE_10] [RULE_03]
      fast_osc_24m_en <= !(deep || off) && (next_src == pmc_pkg::SRC_FAST24 ||
                                            next_src == pmc_pkg::SRC_SLOW ||
                                            next_src == pmc_pkg::SRC_EXT); // [RULE_03]
      fast_osc_72m_en <= !(deep || off) && (next_src == pmc_pkg::SRC_FAST72); // [RULE_04]
      reg_low_bias    <= (next_mode == pmc_pkg::PM_SNOOZE);     // [RULE_04]
      power_nets_off  <= off;                                   // [RULE_08] [RULE_09]
      pin_hold        <= off;                                   // [RULE_08] [RULE_09]
      clk_src         <= next_src;
      clk_div_ratio   <= div_ratio(next_div);                   // [RULE_12]
      clk_pre15       <= next_pre15 && (next_src == pmc_pkg::SRC_FAST24 ||
                                        next_src == pmc_pkg::SRC_FAST72); // [RULE_13]
      power_mode      <= next_mode;
    end
  end

endmodule // pmc_top

// [tb/pmc_checker.sv]
// Concurrent checks on the power mode controller top ports.
// Assumes one clock, core_clk, and the async active-low reset nrst.
`timescale 1ns/1ps
module pmc_checker #(
  parameter int PERIPH_W = 8
) (
  input wire logic                core_clk,
  input wire logic                nrst,
  input wire logic                clk_en,
  input wire logic                irq_any,
  input wire logic                wake_timer4,
  input wire logic                wake_spi,
  input wire logic                wake_i2c,
  input wire logic                wake_port_match,
  input wire logic                cmp0_level,
  input wire logic                wake_clu,
  input wire logic                any_reset,
  input wire logic                pin_or_por_reset,
  input wire logic                core_clk_en,
  input wire logic [PERIPH_W-1:0] periph_clk_en,
  input wire logic                fast_osc_24m_en,
  input wire logic                fast_osc_72m_en,
  input wire logic                reg_low_bias,
  input wire logic                power_nets_off,
  input wire logic                pin_hold,
  input wire logic [1:0]          clk_src,
  input wire logic [7:0]          clk_div_ratio,
  input wire logic                clk_pre15,
  input wire logic [5:0]          power_mode
);
  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic lp;
  // Suspend or snooze in force
  assign lp = (power_mode == 6'h04) || (power_mode == 6'h08);
  // A wake cause seen in suspend or snooze
  sequence s_lp_wake;
    lp && clk_en && (wake_timer4 || wake_spi || wake_i2c || wake_port_match || wake_clu
      || (cmp0_level && !$past(cmp0_level)));
  endsequence
  property p_reset_clk; $rose(nrst) |-> clk_src == 2'h0 && clk_div_ratio == 8'h08; endproperty
  property p_normal; power_mode == 6'h01 |-> core_clk_en; endproperty
  property p_idle; power_mode == 6'h02 |-> !core_clk_en && !power_nets_off; endproperty
  property p_idle_wake; power_mode == 6'h02 && irq_any && clk_en |=> power_mode == 6'h01;
  endproperty
  property p_lp_off;
    lp |-> !core_clk_en && periph_clk_en == '0 && !fast_osc_24m_en && !fast_osc_72m_en
      && reg_low_bias == power_mode[3];
  endproperty
  property p_lp_wake; s_lp_wake |=> power_mode == 6'h01; endproperty
  property p_deep; power_mode inside {6'h10, 6'h20} |-> power_nets_off && pin_hold; endproperty
  property p_stop_exit;
    power_mode == 6'h10 && clk_en && (any_reset || pin_or_por_reset) |=> power_mode == 6'h01;
  endproperty
  property p_shut_hold;
    power_mode == 6'h20 && clk_en && !pin_or_por_reset |=> power_mode == 6'h20;
  endproperty
  property p_div; $onehot(clk_div_ratio); endproperty
  property p_pre15; clk_pre15 |-> clk_src inside {2'h0, 2'h1}; endproperty
  a_reset_clk: assert property (p_reset_clk) else $error("reset clock wrong");
  a_normal: assert property (p_normal) else $error("core clock off in normal");
  a_idle: assert property (p_idle) else $error("idle gating wrong");
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake missed");
  a_lp_off: assert property (p_lp_off) else $error("low power gating wrong");
  a_lp_wake: assert property (p_lp_wake) else $error("low power wake missed");
  a_deep: assert property (p_deep) else $error("deep mode power wrong");
  a_stop_exit: assert property (p_stop_exit) else $error("stop exit missed");
  a_shut_hold: assert property (p_shut_hold) else $error("shutdown left early");
  a_div: assert property (p_div) else $error("divider ratio not a power of two");
  a_pre15: assert property (p_pre15) else $error("prescaler on slow source");
endmodule // pmc_checker

bind pmc_top pmc_checker #(.PERIPH_W(PERIPH_W)) u_chk (.core_clk, .nrst, .clk_en, .irq_any,
  .wake_timer4, .wake_spi, .wake_i2c, .wake_port_match, .cmp0_level, .wake_clu, .any_reset,
  .pin_or_por_reset, .core_clk_en, .periph_clk_en, .fast_osc_24m_en, .fast_osc_72m_en,
  .reg_low_bias, .power_nets_off, .pin_hold, .clk_src, .clk_div_ratio, .clk_pre15, .power_mode);

// [tb/testbench.sv]
// Self-checking bench for the power mode controller.
// Assumes the bench is the only AHB-Lite master; hready follows hreadyout.
`timescale 1ns/1ps
module testbench;
  // ---------------------------------------------------------------------
  // Signals and design
  // ---------------------------------------------------------------------
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0]  ev = 4'h0; // Interrupt, any reset, pin or power-on reset, slow tick
  logic [5:0]  wk = 6'h00;
  logic        ce = 1'b1;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, core_clk_en, osc24, osc72, bias, nets_off, pin_hold;
  logic [7:0]  periph_clk_en, clk_div_ratio;
  logic [1:0]  clk_src;
  logic        clk_pre15, timer34_tick;
  logic [5:0]  power_mode;
  int          fail_count = 0, cmp_count = 0, cyc = 0, ticks = 0;
  pmc_top u_dut (.core_clk, .nrst, .clk_en(ce), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .irq_any(ev[0]),
    .wake_timer4(wk[0]), .wake_spi(wk[1]), .wake_i2c(wk[2]), .wake_port_match(wk[3]),
    .cmp0_level(wk[4]), .wake_clu(wk[5]), .any_reset(ev[1]), .pin_or_por_reset(ev[2]),
    .slow_osc_tick(ev[3]),
    .core_clk_en, .periph_clk_en, .fast_osc_24m_en(osc24), .fast_osc_72m_en(osc72),
    .reg_low_bias(bias), .power_nets_off(nets_off), .pin_hold, .clk_src, .clk_div_ratio,
    .clk_pre15, .timer34_tick, .power_mode);
  // Clock, timer tick count and hang guard
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (timer34_tick === 1'b1) ticks++;
    if (cyc == 6000) begin
      fail_count++;
      finish_test();
    end
  end
  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= pmc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, exp);
    chk(hresp, 1'b0);
  endtask
  task automatic wait_mode(input logic [5:0] exp);
    for (int n = 0; n < 10 && power_mode !== exp; n++) @(posedge core_clk);
    #1;
    chk(power_mode, exp);
  endtask
  task automatic pulse(input int b, input int hold);
    @(posedge core_clk);
    ev[b] <= 1'b1;
    repeat (hold) @(posedge core_clk);
    ev[b] <= 1'b0;
  endtask
  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset();
    chk({clk_src, clk_div_ratio, clk_pre15}, {2'h0, 8'h08, 1'b0});
    chk({core_clk_en, periph_clk_en}, 9'h100);
    rd(pmc_pkg::OFF_STATUS, 32'h1);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
  endtask
  task automatic t_div();
    for (int i = 0; i < 8; i++) begin
      wr(pmc_pkg::OFF_CLK_SEL, 32'h101 | (i << 4));
      chk({osc72, clk_src, clk_pre15, clk_div_ratio}, {1'b1, 2'h1, 1'b1, 8'h1 << i});
    end
    wr(pmc_pkg::OFF_CLK_SEL, 32'h102);
    chk(clk_pre15, 1'b0);
    wr(pmc_pkg::OFF_CLK_SEL, 32'h31);
    wr(pmc_pkg::OFF_PCTL_SECOND, 32'h1);
    chk(power_mode, pmc_pkg::PM_NORMAL);
    rd(pmc_pkg::OFF_PCTL_SECOND, 32'h0);
    wr(pmc_pkg::OFF_CLK_SEL, 32'h30);
  endtask
  task automatic t_idle();
    wr(pmc_pkg::OFF_PERIPH_EN, 32'h5a);
    chk(periph_clk_en, 8'h5a);
    wr(pmc_pkg::OFF_PCTL_FIRST, 32'h1);
    wait_mode(pmc_pkg::PM_IDLE);
    chk({core_clk_en, periph_clk_en}, 9'h05a);
    ce <= 1'b0;
    pulse(0, 1);
    repeat (2) @(posedge core_clk);
    #1;
    chk(power_mode, pmc_pkg::PM_IDLE);
    ce <= 1'b1;
    pulse(0, 1);
    wait_mode(pmc_pkg::PM_NORMAL);
    rd(pmc_pkg::OFF_PCTL_FIRST, 32'h0);
  endtask
  task automatic t_lowpower();
    int t0;
    wr(pmc_pkg::OFF_REG_CTRL, 32'h2);
    for (int i = 0; i < 6; i++) begin
      wr(pmc_pkg::OFF_PCTL_SECOND, (i % 2) ? 32'h2 : 32'h1);
      wait_mode((i % 2) ? pmc_pkg::PM_SNOOZE : pmc_pkg::PM_SUSPEND);
      chk({core_clk_en, osc24, osc72, bias}, (i % 2) ? 4'h1 : 4'h0);
      chk(periph_clk_en, 8'h00);
      if (i == 0) begin
        t0 = ticks;
        repeat (16) pulse(3, 1);
        repeat (3) @(posedge core_clk);
        chk(ticks - t0, 32'h2);
      end
      @(posedge core_clk);
      wk <= 6'h01 << i;
      wait_mode(pmc_pkg::PM_NORMAL);
      wk <= 6'h00;
      rd(pmc_pkg::OFF_PCTL_SECOND, 32'h0);
    end
  endtask
  task automatic t_deep();
    wr(pmc_pkg::OFF_PCTL_FIRST, 32'h2);
    wait_mode(pmc_pkg::PM_STOP);
    chk({nets_off, pin_hold}, 2'h3);
    pulse(1, 1);
    wait_mode(pmc_pkg::PM_NORMAL);
    wr(pmc_pkg::OFF_PCTL_FIRST, 32'h2);
    wait_mode(pmc_pkg::PM_STOP);
    pulse(2, 1);
    wait_mode(pmc_pkg::PM_NORMAL);
    wr(pmc_pkg::OFF_REG_CTRL, 32'h3);
    wr(pmc_pkg::OFF_PCTL_FIRST, 32'h2);
    wait_mode(pmc_pkg::PM_SHUTDOWN);
    chk({nets_off, pin_hold}, 2'h3);
    pulse(1, 4);
    wait_mode(pmc_pkg::PM_SHUTDOWN);
    pulse(2, 1);
    wait_mode(pmc_pkg::PM_NORMAL);
    rd(pmc_pkg::OFF_PCTL_FIRST, 32'h0);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    #1;
    t_reset();
    t_div();
    t_idle();
    t_lowpower();
    t_deep();
    finish_test();
  end
endmodule // testbench
